// ---- hw/fpd_pkg.sv ----
// package: register map, field layout, reset values and codes of the
// first path detector register group.
// assumes: 32-bit axi4-lite access, one aligned word per register.
package fpd_pkg;
  localparam int          ADDR_W       = 16;
  // printed offsets are word indices, byte address is four times that
  localparam int          IDX_THRESH   = 'h0000;
  localparam int          IDX_CFG1     = 'h0806;
  localparam int          IDX_PPINDX   = 'h1000;
  localparam int          IDX_PPAMPL   = 'h1002;
  localparam int          IDX_RXANTD   = 'h1804;
  localparam int          IDX_CFG2     = 'h1806;
  localparam int          IDX_REPC     = 'h2804;
  localparam logic [15:0] A_THRESH     = 16'(IDX_THRESH * 4);
  localparam logic [15:0] A_CFG1       = 16'(IDX_CFG1 * 4);
  localparam logic [15:0] A_PPINDX     = 16'(IDX_PPINDX * 4);
  localparam logic [15:0] A_PPAMPL     = 16'(IDX_PPAMPL * 4);
  localparam logic [15:0] A_RXANTD     = 16'(IDX_RXANTD * 4);
  localparam logic [15:0] A_CFG2       = 16'(IDX_CFG2 * 4);
  localparam logic [15:0] A_REPC       = 16'(IDX_REPC * 4);
  // detect_multipliers fields
  localparam int          NTM_LSB      = 0;
  localparam int          NTM_W        = 5;
  localparam int          PEAK_NOISE_MULTIPLIER_LSB    = 5;
  localparam int          PEAK_NOISE_MULTIPLIER_W      = 3;
  localparam logic [7:0]  CFG1_RST     = 8'h6c;
  localparam logic [15:0] RXANTD_RST   = 16'h0000;
  localparam logic [15:0] CFG2_RST     = 16'h0000;
  localparam logic [15:0] REPC_RST     = 16'h0000;
  localparam logic [15:0] STAT_RST     = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_DECERR  = 2'b11;
  // register selector, one code per mapped word
  typedef enum logic [2:0] {
    FPD_SEL_NONE   = 3'd0,
    FPD_SEL_THRESH = 3'd1,
    FPD_SEL_CFG1   = 3'd2,
    FPD_SEL_PPINDX = 3'd3,
    FPD_SEL_PPAMPL = 3'd4,
    FPD_SEL_RXANTD = 3'd5,
    FPD_SEL_CFG2   = 3'd6,
    FPD_SEL_REPC   = 3'd7
  } fpd_sel_t;
  typedef enum logic [3:0] {
    FPD_IDLE   = 4'b0001,
    FPD_CALC   = 4'b0010,
    FPD_SCAN   = 4'b0100,
    FPD_FINISH = 4'b1000
  } fpd_state_t;
endpackage : fpd_pkg

// ---- hw/fpd_peak_tracker.sv ----
// peak tracker: keeps the largest magnitude seen and its position.
// assumes: clear pulse before the first sample of a run, same clock.
`timescale 1ns/10ps
module fpd_peak_tracker #(
  parameter int MAG_W = 16,
  parameter int IDX_W = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clear,
  input  wire logic             sample_valid,
  input  wire logic [MAG_W-1:0] sample_mag,
  input  wire logic [IDX_W-1:0] sample_idx,
  output logic      [MAG_W-1:0] peak_mag,
  output logic      [IDX_W-1:0] peak_idx
);
  // strict greater-than: ties keep the earliest position
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      peak_mag <= '0;
      peak_idx <= '0;
    end else if (sample_valid && sample_mag > peak_mag) begin
      peak_mag <= sample_mag;
      peak_idx <= sample_idx;
    end
  end
endmodule : fpd_peak_tracker

// ---- hw/fpd_threshold_calc.sv ----
// threshold calculator: noise and peak multipliers, replica raise.
// assumes: inputs stable in the cycle load is high; result one cycle later.
`timescale 1ns/10ps
module fpd_threshold_calc (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        load,
  input  wire logic [15:0] noise_level,
  input  wire logic [15:0] peak_noise,
  input  wire logic [4:0]  noise_mult,
  input  wire logic [2:0]  peak_mult,
  input  wire logic [15:0] replica_coef,
  input  wire logic [7:0]  clock_offset,
  input  wire logic [15:0] floor_value,
  output logic      [15:0] threshold
);
  logic [20:0] noise_thr;
  logic [18:0] peak_thr;
  logic [20:0] base;
  logic [31:0] rep_prod;
  logic [23:0] raise;
  logic [21:0] total;
  always_comb begin
    noise_thr = 21'(noise_level) * 21'(noise_mult);
    // peak factor is half the field value, product kept at full width
    peak_thr  = (19'(peak_noise) * 19'(peak_mult)) >> 1;
    base      = (noise_thr > 21'(peak_thr)) ? noise_thr : 21'(peak_thr);
    rep_prod  = 32'(base[15:0]) * 32'(replica_coef);
    raise     = 24'(rep_prod[31:16]) * 24'(clock_offset);
    total     = 22'(base) + 22'(raise[23:8]);
  end
  // saturate so a huge noise estimate cannot wrap to a low threshold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      threshold <= '0;
    end else if (load) begin
      if (total[21:16] != '0) begin
        threshold <= 16'hffff;
      end else if (total[15:0] < floor_value) begin
        threshold <= floor_value;
      end else begin
        threshold <= total[15:0];
      end
    end
  end
endmodule : fpd_threshold_calc

// ---- hw/fpd_first_path_detector.sv ----
// first path detector register group with axi4-lite slave and analysis run.
// assumes: accumulator samples streamed in order, one per handshake.
`timescale 1ns/10ps
module fpd_first_path_detector #(
  parameter int MAG_W    = 16,
  parameter int IDX_W    = 16,
  parameter int TS_W     = 40,
  parameter int FP_SHIFT = 6
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [15:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [15:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              run_start,
  input  wire logic [15:0]       noise_level,
  input  wire logic [15:0]       peak_noise,
  input  wire logic [7:0]        clock_offset,
  input  wire logic [TS_W-1:0]   raw_receive_timestamp,
  input  wire logic              sample_valid,
  input  wire logic [MAG_W-1:0]  sample_mag,
  input  wire logic              sample_last,
  output logic                   sample_ready,
  output logic [TS_W-1:0]        adjusted_timestamp,
  output logic [IDX_W-1:0]       first_path_index,
  output logic [MAG_W-1:0]       first_path_amplitude,
  output logic                   run_done
);
  function automatic fpd_pkg::fpd_sel_t reg_sel(input logic [15:0] a);
    case (a)
      fpd_pkg::A_THRESH: reg_sel = fpd_pkg::FPD_SEL_THRESH;
      fpd_pkg::A_CFG1:   reg_sel = fpd_pkg::FPD_SEL_CFG1;
      fpd_pkg::A_PPINDX: reg_sel = fpd_pkg::FPD_SEL_PPINDX;
      fpd_pkg::A_PPAMPL: reg_sel = fpd_pkg::FPD_SEL_PPAMPL;
      fpd_pkg::A_RXANTD: reg_sel = fpd_pkg::FPD_SEL_RXANTD;
      fpd_pkg::A_CFG2:   reg_sel = fpd_pkg::FPD_SEL_CFG2;
      fpd_pkg::A_REPC:   reg_sel = fpd_pkg::FPD_SEL_REPC;
      default:           reg_sel = fpd_pkg::FPD_SEL_NONE;
    endcase
  endfunction : reg_sel
  logic [7:0]          detect_multipliers;
  logic [15:0]         receive_antenna_delay;
  logic [15:0]         detect_tuning_prf;
  logic [15:0]         replica_coefficient;
  logic [15:0]         peak_path_index;
  logic [15:0]         peak_path_amplitude;
  logic [15:0]         used_threshold_report;
  logic [15:0]         aw_addr;
  logic                aw_held;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                w_held;
  logic                wr_fire;
  fpd_pkg::fpd_sel_t   wr_sel;
  fpd_pkg::fpd_state_t state;
  fpd_pkg::fpd_state_t next_state;
  logic [IDX_W-1:0]    scan_idx;
  logic                fp_found;
  logic [15:0]         threshold;
  logic [MAG_W-1:0]    trk_mag;
  logic [IDX_W-1:0]    trk_idx;
  logic                sample_fire;
  logic                calc_load;

  // write address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held       <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held       <= 1'b0;
    end else if (!w_held && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel  = reg_sel(aw_addr);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fpd_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == fpd_pkg::FPD_SEL_NONE) ? fpd_pkg::RESP_DECERR
                                                        : fpd_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_multipliers <= fpd_pkg::CFG1_RST;
    end else if (wr_fire && wr_sel == fpd_pkg::FPD_SEL_CFG1 && w_strb[0]) begin
      detect_multipliers <= w_data[7:0];
    end
  end

  // antenna delay, tuning word and replica coefficient
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_antenna_delay <= fpd_pkg::RXANTD_RST;
      detect_tuning_prf     <= fpd_pkg::CFG2_RST;
      replica_coefficient   <= fpd_pkg::REPC_RST;
    end else if (wr_fire) begin
      for (int b = 0; b < 2; b++) begin
        if (w_strb[b]) begin
          case (wr_sel)
            fpd_pkg::FPD_SEL_RXANTD: receive_antenna_delay[b*8 +: 8] <= w_data[b*8 +: 8];
            fpd_pkg::FPD_SEL_CFG2:   detect_tuning_prf[b*8 +: 8]     <= w_data[b*8 +: 8];
            fpd_pkg::FPD_SEL_REPC:   replica_coefficient[b*8 +: 8]   <= w_data[b*8 +: 8];
            default: ;
          endcase
        end
      end
    end
  end

  // read path, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= fpd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= fpd_pkg::RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        fpd_pkg::FPD_SEL_THRESH: s_axi_rdata <= {16'h0000, used_threshold_report};
        fpd_pkg::FPD_SEL_CFG1:   s_axi_rdata <= {24'h00_0000, detect_multipliers};
        fpd_pkg::FPD_SEL_PPINDX: s_axi_rdata <= {16'h0000, peak_path_index};
        fpd_pkg::FPD_SEL_PPAMPL: s_axi_rdata <= {16'h0000, peak_path_amplitude};
        fpd_pkg::FPD_SEL_RXANTD: s_axi_rdata <= {16'h0000, receive_antenna_delay};
        fpd_pkg::FPD_SEL_CFG2:   s_axi_rdata <= {16'h0000, detect_tuning_prf};
        fpd_pkg::FPD_SEL_REPC:   s_axi_rdata <= {16'h0000, replica_coefficient};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= fpd_pkg::RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  always_comb begin
    case (state)
      fpd_pkg::FPD_IDLE:   next_state = run_start ? fpd_pkg::FPD_CALC : fpd_pkg::FPD_IDLE;
      fpd_pkg::FPD_CALC:   next_state = fpd_pkg::FPD_SCAN;
      fpd_pkg::FPD_SCAN:   next_state = (sample_fire && sample_last) ? fpd_pkg::FPD_FINISH
                                                                     : fpd_pkg::FPD_SCAN;
      fpd_pkg::FPD_FINISH: next_state = fpd_pkg::FPD_IDLE;
      default:             next_state = fpd_pkg::FPD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state        <= fpd_pkg::FPD_IDLE;
      sample_ready <= 1'b0;
    end else begin
      state        <= next_state;
      sample_ready <= (next_state == fpd_pkg::FPD_SCAN);
    end
  end

  assign sample_fire = sample_valid && sample_ready;
  assign calc_load   = (state == fpd_pkg::FPD_IDLE) && run_start;
  fpd_threshold_calc u_thr (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .load         (calc_load),
    .noise_level  (noise_level),
    .peak_noise   (peak_noise),
    .noise_mult   (detect_multipliers[fpd_pkg::NTM_LSB +: fpd_pkg::NTM_W]),
    .peak_mult    (detect_multipliers[fpd_pkg::PEAK_NOISE_MULTIPLIER_LSB +: fpd_pkg::PEAK_NOISE_MULTIPLIER_W]),
    .replica_coef (replica_coefficient),
    .clock_offset (clock_offset),
    .floor_value  (detect_tuning_prf),
    .threshold    (threshold)
  );

  fpd_peak_tracker #(
    .MAG_W (MAG_W),
    .IDX_W (IDX_W)
  ) u_peak (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .clear        (calc_load),
    .sample_valid (sample_fire),
    .sample_mag   (sample_mag),
    .sample_idx   (scan_idx),
    .peak_mag     (trk_mag),
    .peak_idx     (trk_idx)
  );

  // first sample above threshold is the leading edge
  always_ff @(posedge aclk) begin
    if (!aresetn || calc_load) begin
      scan_idx             <= '0;
      fp_found             <= 1'b0;
      first_path_index     <= '0;
      first_path_amplitude <= '0;
    end else if (sample_fire) begin
      scan_idx <= scan_idx + IDX_W'(1);
      if (!fp_found && sample_mag > threshold) begin
        fp_found             <= 1'b1;
        first_path_index     <= scan_idx;
        first_path_amplitude <= sample_mag;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_path_index       <= fpd_pkg::STAT_RST;
      peak_path_amplitude   <= fpd_pkg::STAT_RST;
      used_threshold_report <= fpd_pkg::STAT_RST;
    end else if (state == fpd_pkg::FPD_FINISH) begin
      peak_path_index       <= 16'(trk_idx);
      peak_path_amplitude   <= 16'(trk_mag);
      used_threshold_report <= threshold;
    end
  end

  // delay removed, first path offset added
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adjusted_timestamp <= '0;
      run_done           <= 1'b0;
    end else begin
      run_done <= (state == fpd_pkg::FPD_FINISH);
      if (state == fpd_pkg::FPD_FINISH) begin
        adjusted_timestamp <= raw_receive_timestamp - TS_W'(receive_antenna_delay)
                              + (TS_W'(first_path_index) << FP_SHIFT);
      end
    end
  end
  property p_cfg1_reset;
    @(posedge aclk) $past(!aresetn) && aresetn |-> detect_multipliers == fpd_pkg::CFG1_RST;
  endproperty
  a_cfg1_reset: assert property (p_cfg1_reset) else $error("multipliers reset wrong");
  property p_cfg1_write;
    @(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_sel == fpd_pkg::FPD_SEL_CFG1 && w_strb[0]
      |=> detect_multipliers == $past(w_data[7:0]);
  endproperty
  a_cfg1_write: assert property (p_cfg1_write) else $error("octet write lost");
  property p_antd_write;
    @(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_sel == fpd_pkg::FPD_SEL_RXANTD && w_strb == 4'hf
      |=> receive_antenna_delay == $past(w_data[15:0]);
  endproperty
  a_antd_write: assert property (p_antd_write) else $error("antenna delay not stored");
  property p_peak_index;
    @(posedge aclk) disable iff (!aresetn)
    state == fpd_pkg::FPD_FINISH |=> peak_path_index == $past(trk_idx) && run_done;
  endproperty
  a_peak_index: assert property (p_peak_index) else $error("peak index not recorded");
  property p_peak_ampl;
    @(posedge aclk) disable iff (!aresetn)
    sample_fire && sample_mag > trk_mag |=> trk_mag == $past(sample_mag);
  endproperty
  a_peak_ampl: assert property (p_peak_ampl) else $error("peak amplitude missed");
  property p_stamp;
    @(posedge aclk) disable iff (!aresetn)
    state == fpd_pkg::FPD_FINISH |=> adjusted_timestamp == $past(raw_receive_timestamp)
      - TS_W'($past(receive_antenna_delay)) + (TS_W'($past(first_path_index)) << FP_SHIFT);
  endproperty
  a_stamp: assert property (p_stamp) else $error("timestamp adjust wrong");
  property p_thr_floor;
    @(posedge aclk) disable iff (!aresetn)
    calc_load |=> threshold >= $past(detect_tuning_prf);
  endproperty
  a_thr_floor: assert property (p_thr_floor) else $error("threshold under floor");
  property p_thr_report;
    @(posedge aclk) disable iff (!aresetn)
    run_done |-> used_threshold_report == threshold;
  endproperty
  a_thr_report: assert property (p_thr_report) else $error("threshold report stale");
  property p_sequence;
    @(posedge aclk) disable iff (!aresetn)
    calc_load |=> state == fpd_pkg::FPD_CALC ##1 state == fpd_pkg::FPD_SCAN && sample_ready;
  endproperty
  a_sequence: assert property (p_sequence) else $error("run sequence broken");
  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
    state != fpd_pkg::FPD_FINISH |=> $stable(peak_path_amplitude) && $stable(peak_path_index);
  endproperty
  a_hold: assert property (p_hold) else $error("status changed mid run");
  property p_cov_run;
    @(posedge aclk) disable iff (!aresetn) fp_found && run_done;
  endproperty
  c_cov_run: cover property (p_cov_run);
  property p_cov_decerr;
    @(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bresp == fpd_pkg::RESP_DECERR;
  endproperty
  c_cov_decerr: cover property (p_cov_decerr);
  property p_cov_read;
    @(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready;
  endproperty
  c_cov_read: cover property (p_cov_read);
endmodule : fpd_first_path_detector

// ---- tb/fpd_first_path_detector_tb.sv ----
// bench: register group over axi4-lite plus four analysis runs.
// assumes: no partner model, bench drives every port, default parameters.
`timescale 1ns/10ps
module fpd_first_path_detector_tb;
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [15:0] awaddr        = 16'h0000;
  logic        awvalid       = 1'b0;
  logic [31:0] wdata         = 32'h0000_0000;
  logic [3:0]  wstrb         = 4'h0;
  logic        wvalid        = 1'b0;
  logic        bready        = 1'b0;
  logic [15:0] araddr        = 16'h0000;
  logic        arvalid       = 1'b0;
  logic        rready        = 1'b0;
  logic        run_start     = 1'b0;
  logic [15:0] noise_level   = 16'h0000;
  logic [15:0] peak_noise    = 16'h0000;
  logic [7:0]  clock_offset  = 8'h00;
  logic [39:0] raw_ts        = 40'h00_0000_0000;
  logic        sample_valid  = 1'b0;
  logic [15:0] sample_mag    = 16'h0000;
  logic        sample_last   = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sample_ready, run_done;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [39:0] adj_ts;
  logic [15:0] fp_idx, fp_amp;
  int          failures      = 0;
  int          tests_run     = 0;
  int          cycles        = 0;

  fpd_first_path_detector i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .run_start(run_start),
    .noise_level(noise_level), .peak_noise(peak_noise), .clock_offset(clock_offset),
    .raw_receive_timestamp(raw_ts), .sample_valid(sample_valid),
    .sample_mag(sample_mag), .sample_last(sample_last), .sample_ready(sample_ready),
    .adjusted_timestamp(adj_ts), .first_path_index(fp_idx),
    .first_path_amplitude(fp_amp), .run_done(run_done)
  );

  always #2.5 aclk = ~aclk;

  // whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // slave may take address and data in either order
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awready && !ta) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !tw) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    check(40'(bresp), 40'(er));
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    check(40'(rdata), 40'(exp));
    check(40'(rresp), 40'(er));
    @(posedge aclk);
  endtask : rd

  // released stream shows the inverse so stale data cannot pass
  task automatic run(input logic [15:0] nz, input logic [15:0] pk, input logic [7:0] off,
                     input logic [15:0] s [6], input int n);
    run_start <= 1'b1;
    noise_level <= nz;
    peak_noise <= pk;
    clock_offset <= off;
    @(posedge aclk);
    run_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sample_valid <= 1'b1;
      sample_mag <= s[i];
      sample_last <= (i == n - 1);
      do @(posedge aclk); while (!sample_ready);
    end
    sample_valid <= 1'b0;
    sample_last <= 1'b0;
    sample_mag <= ~s[n-1];
    do @(posedge aclk); while (!run_done);
    @(posedge aclk);
    check(40'(run_done), 40'h00_0000_0000);
  endtask : run

  task automatic t_reset_values();
    logic [15:0] a [7] = '{fpd_pkg::A_THRESH, fpd_pkg::A_CFG1, fpd_pkg::A_PPINDX,
                           fpd_pkg::A_PPAMPL, fpd_pkg::A_RXANTD, fpd_pkg::A_CFG2,
                           fpd_pkg::A_REPC};
    for (int i = 0; i < 7; i++) begin
      rd(a[i], (i == 1) ? 32'h0000_006c : 32'h0000_0000, 2'b00);
    end
    rd(16'h0008, 32'h0000_0000, 2'b11);
  endtask : t_reset_values

  task automatic t_run_noise();
    wr(fpd_pkg::A_CFG1, 32'h0000_0002, 4'h1, 2'b00);
    wr(fpd_pkg::A_RXANTD, 32'h0000_0010, 4'h3, 2'b00);
    raw_ts <= 40'h00_0010_0000;
    run(16'h000a, 16'h0005, 8'h00,
        '{16'h0005, 16'h001e, 16'h0019, 16'h0032, 16'h0032, 16'h0008}, 6);
    check(adj_ts, 40'h00_0010_0030);
    check(40'(fp_idx), 40'h00_0000_0001);
    check(40'(fp_amp), 40'h00_0000_001e);
    rd(fpd_pkg::A_THRESH, 32'h0000_0014, 2'b00);
    rd(fpd_pkg::A_PPINDX, 32'h0000_0003, 2'b00);
    rd(fpd_pkg::A_PPAMPL, 32'h0000_0032, 2'b00);
  endtask : t_run_noise

  // peak multiplier four gives factor two, replica half, offset half
  task automatic t_run_replica();
    wr(fpd_pkg::A_CFG1, 32'h0000_0081, 4'h1, 2'b00);
    wr(fpd_pkg::A_REPC, 32'h0000_8000, 4'h3, 2'b00);
    raw_ts <= 40'h12_3456_7890;
    run(16'h000a, 16'h0014, 8'h80,
        '{16'h002d, 16'h0032, 16'h0033, 16'h003c, 16'h0000, 16'h0000}, 4);
    check(adj_ts, 40'h12_3456_7900);
    check(40'(fp_idx), 40'h00_0000_0002);
    rd(fpd_pkg::A_THRESH, 32'h0000_0032, 2'b00);
    rd(fpd_pkg::A_PPAMPL, 32'h0000_003c, 2'b00);
    wr(fpd_pkg::A_PPINDX, 32'h0000_ffff, 4'hf, 2'b00);
    rd(fpd_pkg::A_PPINDX, 32'h0000_0003, 2'b00);
    check(adj_ts, 40'h12_3456_7900);
  endtask : t_run_replica

  task automatic t_config();
    wr(fpd_pkg::A_CFG1, 32'h0000_0007, 4'h1, 2'b00);
    wr(fpd_pkg::A_CFG1, 32'h0000_ff00, 4'h2, 2'b00);
    rd(fpd_pkg::A_CFG1, 32'h0000_0007, 2'b00);
    wr(fpd_pkg::A_CFG1, 32'h0000_00e0, 4'h1, 2'b00);
    rd(fpd_pkg::A_CFG1, 32'h0000_00e0, 2'b00);
    wr(fpd_pkg::A_RXANTD, 32'hffff_abcd, 4'hf, 2'b00);
    rd(fpd_pkg::A_RXANTD, 32'h0000_abcd, 2'b00);
    wr(fpd_pkg::A_CFG2, 32'h0000_1607, 4'h3, 2'b00);
    rd(fpd_pkg::A_CFG2, 32'h0000_1607, 2'b00);
    wr(fpd_pkg::A_CFG2, 32'h0000_0607, 4'h3, 2'b00);
    rd(fpd_pkg::A_CFG2, 32'h0000_0607, 2'b00);
    wr(fpd_pkg::A_REPC, 32'h0000_0b33, 4'h3, 2'b00);
    rd(fpd_pkg::A_REPC, 32'h0000_0b33, 2'b00);
    wr(16'h0008, 32'h0000_1234, 4'hf, 2'b11);
  endtask : t_config

  // tuning word as floor, then a peak estimate that saturates
  task automatic t_run_floor();
    raw_ts <= 40'h00_0001_0000;
    run(16'h000a, 16'h0010, 8'h00,
        '{16'h0600, 16'h0607, 16'h0608, 16'h0700, 16'h0000, 16'h0000}, 4);
    check(40'(fp_idx), 40'h00_0000_0002);
    check(40'(fp_amp), 40'h00_0000_0608);
    check(adj_ts, 40'h00_0000_54b3);
    rd(fpd_pkg::A_THRESH, 32'h0000_0607, 2'b00);
    rd(fpd_pkg::A_PPINDX, 32'h0000_0003, 2'b00);
    run(16'h000a, 16'hffff, 8'h00,
        '{16'hfffe, 16'hffff, 16'h0001, 16'h0000, 16'h0000, 16'h0000}, 3);
    check(40'(fp_idx), 40'h00_0000_0000);
    check(40'(fp_amp), 40'h00_0000_0000);
    check(adj_ts, 40'h00_0000_5433);
    rd(fpd_pkg::A_THRESH, 32'h0000_ffff, 2'b00);
    rd(fpd_pkg::A_PPINDX, 32'h0000_0001, 2'b00);
    rd(fpd_pkg::A_PPAMPL, 32'h0000_ffff, 2'b00);
  endtask : t_run_floor

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_run_noise();
    t_run_replica();
    t_config();
    t_run_floor();
    print_verdict();
  end
endmodule : fpd_first_path_detector_tb
